// ---- pkg/dcwd_regs.svh ----
`ifndef DCWD_REGS_SVH
`define DCWD_REGS_SVH

// ==========================================================
// word layout
`define DCWD_ADDR_HI 15
`define DCWD_ADDR_LO 14
`define DCWD_ADDR_CTRL 2'h0
`define DCWD_ADDR_FREQ_A 2'h1
`define DCWD_ADDR_FREQ_B 2'h2
`define DCWD_ADDR_PHASE 2'h3

// ==========================================================
// control field positions
`define DCWD_BIT_FULL_WORD 13
`define DCWD_BIT_HALF_UPPER 12
`define DCWD_BIT_FREQ_SEL 11
`define DCWD_BIT_PHASE_SEL 10
`define DCWD_BIT_PIN_OR_SW 9
`define DCWD_BIT_RESET 8
`define DCWD_BIT_CLOCK_GATE 7
`define DCWD_BIT_DAC_DOWN 6
`define DCWD_BIT_PHASE_BANK 13

// ==========================================================
// widths, reset values, timing
`define DCWD_CTRL_W 14
`define DCWD_HALF_W 14
`define DCWD_FREQ_W 28
`define DCWD_PHASE_W 12
`define DCWD_CTRL_RESET 14'h0000
`define DCWD_PIN_LATENCY 8

`endif

// ---- pkg/dcwd_pkg.sv ----
package dcwd_pkg;

  // full-word load sequencing
  typedef enum logic [0:0] {
    dcwd_st_idle = 1'b0,
    dcwd_st_have_low = 1'b1
  } dcwd_load_state_t;

  typedef logic [1:0] dcwd_addr_t;

endpackage

// ---- src/dcwd_control_word_decoder.sv ----
`include "dcwd_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module dcwd_control_word_decoder #(
  parameter int PIN_LATENCY = `DCWD_PIN_LATENCY
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // deserialised 16-bit words, same clock domain
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  // asynchronous control pins
  input wire logic freq_select_pin,
  input wire logic phase_select_pin,
  input wire logic reset_pin,
  input wire logic sleep_pin,
  // register contents
  output logic [`DCWD_CTRL_W-1:0] waveform_control_word,
  output logic [`DCWD_FREQ_W-1:0] freq_word_a,
  output logic [`DCWD_FREQ_W-1:0] freq_word_b,
  output logic [`DCWD_PHASE_W-1:0] phase_offset_a,
  output logic [`DCWD_PHASE_W-1:0] phase_offset_b,
  // datapath controls
  output logic [`DCWD_FREQ_W-1:0] freq_inc,
  output logic [`DCWD_PHASE_W-1:0] phase_add,
  output logic [`DCWD_PHASE_W-1:0] phase_out,
  output logic accum_clk_en,
  output logic dac_power_down,
  output logic core_reset
);

  // ==========================================================
  // word decode
  function automatic logic [`DCWD_FREQ_W-1:0] merge_half(
    input logic [`DCWD_FREQ_W-1:0] old_word,
    input logic [`DCWD_HALF_W-1:0] half,
    input logic upper
  );
    logic [`DCWD_FREQ_W-1:0] res;
    res = old_word;
    if (upper) begin
      res[`DCWD_FREQ_W-1:`DCWD_HALF_W] = half;
    end else begin
      res[`DCWD_HALF_W-1:0] = half;
    end
    return res;
  endfunction

  dcwd_pkg::dcwd_addr_t addr;
  logic freq_wr;
  logic freq_idx;
  logic [`DCWD_HALF_W-1:0] wr_half;

  assign addr = word_data[`DCWD_ADDR_HI:`DCWD_ADDR_LO];
  assign freq_wr = word_valid && (addr == `DCWD_ADDR_FREQ_A || addr == `DCWD_ADDR_FREQ_B);
  assign freq_idx = addr[1];
  assign wr_half = word_data[`DCWD_HALF_W-1:0];

  // ==========================================================
  // control word
  logic [`DCWD_CTRL_W-1:0] ctrl_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_r <= `DCWD_CTRL_RESET;
    end else if (word_valid && addr == `DCWD_ADDR_CTRL) begin
      ctrl_r <= word_data[`DCWD_CTRL_W-1:0];
    end
  end

  logic full_mode;
  logic pin_mode;
  assign full_mode = ctrl_r[`DCWD_BIT_FULL_WORD];
  assign pin_mode = ctrl_r[`DCWD_BIT_PIN_OR_SW];

  // ==========================================================
  // frequency registers
  logic [`DCWD_FREQ_W-1:0] freq_r [2];
  logic [`DCWD_HALF_W-1:0] low_hold_r;
  dcwd_pkg::dcwd_load_state_t load_st_r;

  // a full-word pair is not address-checked; second word's address wins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      load_st_r <= dcwd_pkg::dcwd_st_idle;
      low_hold_r <= 14'h0000;
    end else if (!full_mode) begin
      load_st_r <= dcwd_pkg::dcwd_st_idle;
    end else if (freq_wr) begin
      case (load_st_r)
        dcwd_pkg::dcwd_st_idle: begin
          low_hold_r <= wr_half;
          load_st_r <= dcwd_pkg::dcwd_st_have_low;
        end
        dcwd_pkg::dcwd_st_have_low: begin
          load_st_r <= dcwd_pkg::dcwd_st_idle;
        end
        default: begin
          load_st_r <= dcwd_pkg::dcwd_st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      freq_r[0] <= 28'h0000000;
      freq_r[1] <= 28'h0000000;
    end else if (freq_wr) begin
      if (full_mode) begin
        // half-select is not consulted here
        if (load_st_r == dcwd_pkg::dcwd_st_have_low) begin
          freq_r[freq_idx] <= {wr_half, low_hold_r};
        end
      end else begin
        freq_r[freq_idx] <= merge_half(freq_r[freq_idx], wr_half,
                                       ctrl_r[`DCWD_BIT_HALF_UPPER]);
      end
    end
  end

  // ==========================================================
  // phase registers
  logic [`DCWD_PHASE_W-1:0] phase_r [2];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      phase_r[0] <= 12'h000;
      phase_r[1] <= 12'h000;
    end else if (word_valid && addr == `DCWD_ADDR_PHASE) begin
      phase_r[word_data[`DCWD_BIT_PHASE_BANK]] <= word_data[`DCWD_PHASE_W-1:0];
    end
  end

  // ==========================================================
  // pin synchronisers and select latency
  // the first two stages are the synchroniser; the rest make up the latency
  logic [PIN_LATENCY-2:0] freq_bank_select_pipe_r;
  logic [PIN_LATENCY-2:0] psel_pipe_r;
  logic [1:0] rst_sync_r;
  logic [1:0] sleep_sync_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      freq_bank_select_pipe_r <= '0;
      psel_pipe_r <= '0;
    end else begin
      freq_bank_select_pipe_r <= {freq_bank_select_pipe_r[PIN_LATENCY-3:0], freq_select_pin};
      psel_pipe_r <= {psel_pipe_r[PIN_LATENCY-3:0], phase_select_pin};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
      sleep_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], reset_pin};
      sleep_sync_r <= {sleep_sync_r[0], sleep_pin};
    end
  end

  // ==========================================================
  // source selection
  logic freq_bank_select_eff;
  logic psel_eff;
  logic reset_eff;
  logic sleep_eff;

  always_comb begin
    if (pin_mode) begin
      freq_bank_select_eff = freq_bank_select_pipe_r[PIN_LATENCY-2];
      psel_eff = psel_pipe_r[PIN_LATENCY-2];
      reset_eff = rst_sync_r[1];
      sleep_eff = sleep_sync_r[1];
    end else begin
      freq_bank_select_eff = ctrl_r[`DCWD_BIT_FREQ_SEL];
      psel_eff = ctrl_r[`DCWD_BIT_PHASE_SEL];
      reset_eff = ctrl_r[`DCWD_BIT_RESET];
      sleep_eff = ctrl_r[`DCWD_BIT_DAC_DOWN];
    end
  end

  logic [`DCWD_FREQ_W-1:0] freq_inc_r;
  logic [`DCWD_PHASE_W-1:0] phase_add_r;
  logic core_reset_r;
  logic dac_down_r;
  logic clk_en_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      freq_inc_r <= 28'h0000000;
      phase_add_r <= 12'h000;
    end else begin
      freq_inc_r <= freq_r[freq_bank_select_eff];
      phase_add_r <= phase_r[psel_eff];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      core_reset_r <= 1'b0;
      dac_down_r <= 1'b0;
      clk_en_r <= 1'b1;
    end else begin
      core_reset_r <= reset_eff;
      dac_down_r <= sleep_eff;
      clk_en_r <= !ctrl_r[`DCWD_BIT_CLOCK_GATE];
    end
  end

  // ==========================================================
  // phase accumulator
  // gating is a clock enable, so no edge is ever suppressed on the tree
  logic [`DCWD_FREQ_W-1:0] acc_r;
  logic [`DCWD_PHASE_W-1:0] phase_out_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      acc_r <= 28'h0000000;
      phase_out_r <= 12'h000;
    end else if (core_reset_r) begin
      acc_r <= 28'h0000000;
      phase_out_r <= 12'h000;
    end else if (clk_en_r) begin
      acc_r <= acc_r + freq_inc_r;
      phase_out_r <= acc_r[`DCWD_FREQ_W-1:`DCWD_FREQ_W-`DCWD_PHASE_W] + phase_add_r;
    end
  end

  // ==========================================================
  // outputs
  assign waveform_control_word = ctrl_r;
  assign freq_word_a = freq_r[0];
  assign freq_word_b = freq_r[1];
  assign phase_offset_a = phase_r[0];
  assign phase_offset_b = phase_r[1];
  assign freq_inc = freq_inc_r;
  assign phase_add = phase_add_r;
  assign phase_out = phase_out_r;
  assign accum_clk_en = clk_en_r;
  assign dac_power_down = dac_down_r;
  assign core_reset = core_reset_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_full_first_held: assert property (
    freq_wr && full_mode && load_st_r == dcwd_pkg::dcwd_st_idle
    |=> $stable(freq_r[0]) && $stable(freq_r[1]))
    else $error("first half of full word reached a frequency register");

  a_full_second_load: assert property (
    freq_wr && full_mode && load_st_r == dcwd_pkg::dcwd_st_have_low
    |=> freq_r[$past(freq_idx)] == {$past(wr_half), $past(low_hold_r)})
    else $error("full word pair not loaded as low then high");

  a_half_upper: assert property (
    freq_wr && !full_mode && ctrl_r[`DCWD_BIT_HALF_UPPER]
    |=> freq_r[$past(freq_idx)][27:14] == $past(wr_half)
        && freq_r[$past(freq_idx)][13:0] == $past(freq_r[freq_idx][13:0]))
    else $error("upper half write wrong or lower half disturbed");

  a_half_lower: assert property (
    freq_wr && !full_mode && !ctrl_r[`DCWD_BIT_HALF_UPPER]
    |=> freq_r[$past(freq_idx)][13:0] == $past(wr_half)
        && freq_r[$past(freq_idx)][27:14] == $past(freq_r[freq_idx][27:14]))
    else $error("lower half write wrong or upper half disturbed");

  a_half_other_kept: assert property (
    freq_wr && !full_mode |=> freq_r[!$past(freq_idx)] == $past(freq_r[!freq_idx]))
    else $error("half write touched the other frequency register");

  a_sw_freq_sel: assert property (
    !pin_mode |=> freq_inc_r == $past(freq_r[ctrl_r[`DCWD_BIT_FREQ_SEL]]))
    else $error("software frequency select not followed");

  a_sw_phase_sel: assert property (
    !pin_mode |=> phase_add_r == $past(phase_r[ctrl_r[`DCWD_BIT_PHASE_SEL]]))
    else $error("software phase select not followed");

  a_pin_latency: assert property (
    pin_mode [*8] |-> freq_bank_select_pipe_r[PIN_LATENCY-2] == $past(freq_select_pin, 7))
    else $error("frequency select pin latency wrong");

  a_pin_reset: assert property (
    pin_mode [*3] |=> core_reset_r == $past(reset_pin, 3))
    else $error("reset pin not in control under pin mode");

  a_reset_midscale: assert property (
    core_reset_r |=> acc_r == 28'h0000000 && phase_out_r == 12'h000)
    else $error("reset did not clear the accumulator");

  a_gate_halts: assert property (
    !clk_en_r && !core_reset_r |=> $stable(acc_r))
    else $error("accumulator moved while clock gated");

  c_full_pair: cover property (
    freq_wr && full_mode ##[1:20] freq_wr && full_mode);
  c_half_upper: cover property (freq_wr && !full_mode && ctrl_r[`DCWD_BIT_HALF_UPPER]);
  c_pin_switch: cover property (pin_mode && $rose(freq_bank_select_pipe_r[PIN_LATENCY-2]));
  c_gate_resume: cover property (!clk_en_r ##1 clk_en_r);

endmodule

`default_nettype wire

// ---- verif/dcwd_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// host writing deserialised words
module dcwd_host_model (
  // clock
  input wire logic clk_sys,
  // word bus
  output logic word_valid,
  output logic [15:0] word_data
);
  initial begin
    word_valid = 1'b0;
    word_data = 16'h0000;
  end

  // callers keep pair addresses equal and alternate banks
  task automatic send(input logic [15:0] w);
    @(posedge clk_sys);
    #1;
    word_valid = 1'b1;
    word_data = w;
    @(posedge clk_sys);
    #1;
    word_valid = 1'b0;
    // idle data inverted so a stale word never looks valid
    word_data = ~w;
  endtask
endmodule

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// bench
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic fsp = 1'b0;
  logic psp = 1'b0;
  logic rsp = 1'b0;
  logic slp = 1'b0;
  logic word_valid;
  logic [15:0] word_data;
  logic [13:0] ctl;
  logic [27:0] fwa, fwb, finc;
  logic [11:0] pa_o, pb_o, padd, pout;
  logic clk_en, dac_dn, crst;
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'hAA2CA751;
  logic [27:0] fa = 28'h0;
  logic [27:0] fb = 28'h0;
  logic [11:0] pa = 12'h000;
  logic [11:0] pb = 12'h000;
  logic [13:0] lo, hi;
  logic [1:0] ad;
  logic [11:0] po;

  always #4 clk_sys = ~clk_sys;

  dcwd_host_model u_host (.clk_sys(clk_sys), .word_valid(word_valid), .word_data(word_data));

  dcwd_control_word_decoder #(.PIN_LATENCY(8)) u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .word_valid(word_valid), .word_data(word_data),
    .freq_select_pin(fsp), .phase_select_pin(psp), .reset_pin(rsp), .sleep_pin(slp),
    .waveform_control_word(ctl), .freq_word_a(fwa), .freq_word_b(fwb),
    .phase_offset_a(pa_o), .phase_offset_b(pb_o), .freq_inc(finc), .phase_add(padd),
    .phase_out(pout), .accum_clk_en(clk_en), .dac_power_down(dac_dn), .core_reset(crst)
  );

  function automatic logic [13:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[13:0];
  endfunction

  task automatic chk(input string nm, input logic [27:0] exp, input logic [27:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // whole run is under two hundred cycles
  initial begin
    #(8 * 5000);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    chk("ctrl_rst", 28'h0, 28'(ctl));
    chk("clk_en_rst", 28'h1, 28'(clk_en));
    // full-word pairs; upper-select set midway must not matter
    u_host.send(16'h2000);
    for (int i = 0; i < 4; i++) begin
      ad = i[0] ? 2'h2 : 2'h1;
      lo = rnd();
      hi = rnd();
      u_host.send({ad, lo});
      chk("held", i[0] ? fb : fa, i[0] ? fwb : fwa);
      u_host.send({ad, hi});
      if (i[0]) fb = {hi, lo};
      else fa = {hi, lo};
      chk("full", i[0] ? fb : fa, i[0] ? fwb : fwa);
      if (i == 1) u_host.send(16'h3000);
    end
    // half-word writes, both halves, both banks
    for (int i = 0; i < 6; i++) begin
      ad = i[0] ? 2'h2 : 2'h1;
      lo = rnd();
      u_host.send({3'h0, i[1], 12'h000});
      u_host.send({ad, lo});
      if (i[0]) fb = i[1] ? {lo, fb[13:0]} : {fb[27:14], lo};
      else fa = i[1] ? {lo, fa[13:0]} : {fa[27:14], lo};
      chk("half", i[0] ? fb : fa, i[0] ? fwb : fwa);
    end
    pa = 12'(rnd());
    pb = 12'(rnd());
    u_host.send({4'hC, pa});
    u_host.send({4'hE, pb});
    chk("phase_a", 28'(pa), 28'(pa_o));
    chk("phase_b", 28'(pb), 28'(pb_o));
    // software bank selection, every combination
    for (int s = 0; s < 4; s++) begin
      u_host.send({4'h0, s[1:0], 10'h000});
      cyc(2);
      chk("finc_sw", s[1] ? fb : fa, finc);
      chk("padd_sw", 28'(s[0] ? pb : pa), 28'(padd));
    end
    u_host.send(16'h01C0);
    cyc(3);
    chk("core_rst", 28'h1, 28'(crst));
    chk("phase_out", 28'h0, 28'(pout));
    chk("dac_dn", 28'h1, 28'(dac_dn));
    chk("clk_gate", 28'h0, 28'(clk_en));
    u_host.send(16'h0000);
    cyc(2);
    chk("clk_resume", 28'h1, 28'(clk_en));
    chk("core_run", 28'h0, 28'(crst));
    // pin mode; control select bits left at bank a
    u_host.send(16'h0200);
    fsp = 1'b1;
    psp = 1'b1;
    cyc(7);
    chk("pin_early", fa, finc);
    cyc(1);
    chk("pin_freq", fb, finc);
    chk("pin_phase", 28'(pb), 28'(padd));
    rsp = 1'b1;
    slp = 1'b1;
    cyc(4);
    chk("pin_rst", 28'h1, 28'(crst));
    chk("pin_sleep", 28'h1, 28'(dac_dn));
    // random pin levels, all four pins together
    for (int k = 0; k < 4; k++) begin
      lo = rnd();
      fsp = lo[0];
      psp = lo[1];
      rsp = lo[2];
      slp = lo[3];
      cyc(8);
      chk("pin_freq_rnd", lo[0] ? fb : fa, finc);
      chk("pin_phase_rnd", 28'(lo[1] ? pb : pa), 28'(padd));
      chk("pin_rst_rnd", 28'(lo[2]), 28'(crst));
      chk("pin_sleep_rnd", 28'(lo[3]), 28'(dac_dn));
    end
    // back to software: pins all high must be ignored
    fsp = 1'b1;
    psp = 1'b1;
    rsp = 1'b1;
    slp = 1'b1;
    u_host.send(16'h0000);
    cyc(2);
    chk("sw_freq_back", fa, finc);
    chk("sw_phase_back", 28'(pa), 28'(padd));
    chk("sw_rst_back", 28'h0, 28'(crst));
    chk("sw_sleep_back", 28'h0, 28'(dac_dn));
    // gate while running: phase output must freeze
    u_host.send(16'h0080);
    cyc(2);
    po = pout;
    cyc(4);
    chk("gate_hold", 28'(po), 28'(pout));
    end_of_test();
  end
endmodule

`default_nettype wire
